// file: rtl/dio_pkg.sv
package dio_pkg;
  localparam int NUM_DIN = 11;
  localparam int NUM_CH = 2;
  localparam int NUM_SENSE = 3;
  localparam int FAIL_LIMIT_DEF = 8;
  localparam int FAIL_CNT_W = 8;
  // Poll byte fields
  localparam int POLL_OUT0_BIT = 0;
  localparam int POLL_OUT1_BIT = 1;
  // Response byte 2 fields
  localparam int RSP2_HOLD0_BIT = 3;
  localparam int RSP2_COIL0_BIT = 4;
  localparam int RSP2_COIL1_BIT = 5;
  localparam int RSP2_SUP0_BIT = 6;
  localparam int RSP2_SUP1_BIT = 7;
  // Diagnostic byte fields
  localparam int DIAG_VOLT_OFF_BIT = 0;
  localparam logic [1:0] OUT_RESET = 2'h3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic [NUM_DIN-1:0] din_n;
    logic [NUM_CH-1:0] coil_ok_n;
    logic [NUM_CH-1:0] supply_present_n;
    logic [NUM_CH-1:0] hold_status_n;
  } dio_image_t;

  typedef struct packed {
    logic [7:0] byte2;
    logic [7:0] byte1;
  } dio_resp_t;
endpackage : dio_pkg

// file: rtl/dio_sync.sv
module dio_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule : dio_sync

// file: rtl/dio_fail_cnt.sv
module dio_fail_cnt
  import dio_pkg::*;
#(
  parameter int FAIL_LIMIT = FAIL_LIMIT_DEF
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic scan_i,
  input wire logic any_volt_i,
  output logic override_o,
  output logic [FAIL_CNT_W-1:0] count_o
);
  localparam logic [FAIL_CNT_W-1:0] CNT_MAX = '1;
  localparam logic [FAIL_CNT_W-1:0] LIMIT = FAIL_CNT_W'(FAIL_LIMIT);
  logic [FAIL_CNT_W-1:0] cnt_ff;
  logic [FAIL_CNT_W-1:0] nxt_cnt;

  // Clear while any voltage, saturating count otherwise
  assign nxt_cnt = any_volt_i ? '0 :
                   (cnt_ff == CNT_MAX) ? cnt_ff :
                   cnt_ff + 1'b1;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
    end else if (ce_i && scan_i) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign override_o = (cnt_ff > LIMIT);
  assign count_o = cnt_ff;
endmodule : dio_fail_cnt

// file: rtl/dio_scan.sv
// Overview of operation
// - Each scan samples 11 inputs, coil, supply, hold and three sense lines.
// - Sense lines are read every scan; both input bytes only on scans that update the image.
// - Image updates only with a sense voltage present, unless overridden.
// - Any sense line off sets the voltage-off diagnostic bit.
// - Failure counter increments each scan with all sense voltages absent.
// - Counter above limit forces image update without sense voltage.
// - Failure counter held at zero while any sense voltage present.
// - Coil status reported true while its output is on.
// - Bits 0 and 1 of the normal update message byte are written into the output latch.
// - Poll bit 0 drives channel 0, bit 1 channel 1, active low.
// - Response bytes carry inputs, hold0, coils and supplies per layout.
// - Hold status is captured in the image only on scans that update the image.
// - On link timeout, channels with hold true stay energized.
// - On link timeout, channels with hold false are cleared off.
// - Output drive and coil monitor never enabled together.
// - All sensed status inputs are active low.
module dio_scan
  import dio_pkg::*;
#(
  parameter int FAIL_LIMIT = FAIL_LIMIT_DEF
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic scan_tick_i,
  input wire dio_pkg::dio_image_t image_n_i,
  input wire logic sense_volt_a_n_i,
  input wire logic sense_volt_b_n_i,
  input wire logic sense_volt_c_n_i,
  input wire logic point_message_valid_i,
  input wire logic [7:0] point_message_data_i,
  input wire logic interlink_timeout_i,
  output logic out0_drive_n_o,
  output logic out1_drive_n_o,
  output logic [1:0] coil_mon_en_o,
  output dio_pkg::dio_resp_t resp_o,
  output logic [7:0] diag_o,
  output logic volt_fail_override_o,
  output logic [FAIL_CNT_W-1:0] volt_fail_count_o
);
  localparam int IMG_W = $bits(dio_image_t);

  dio_image_t img_s;
  dio_image_t work_ff;
  logic [NUM_SENSE-1:0] sense_n_s;
  logic [1:0] out_n_ff;
  logic [1:0] nxt_out_n;
  logic [1:0] out_on;
  logic [7:0] resp1_ff;
  logic [7:0] resp2_ff;
  logic [7:0] diag_ff;
  logic [7:0] nxt_resp1;
  logic [7:0] nxt_resp2;
  logic [7:0] nxt_diag;
  logic [1:0] coil_rep;
  logic [1:0] hold_on;
  logic any_volt;
  logic all_volt;
  logic override;
  logic take_img;
  logic scan_go;

  // Pin synchronisers
  dio_sync #(
    .WIDTH(IMG_W)
  ) u_img_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .async_i(image_n_i),
    .sync_o(img_s)
  );

  dio_sync #(
    .WIDTH(NUM_SENSE)
  ) u_sense_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .async_i({sense_volt_c_n_i, sense_volt_b_n_i, sense_volt_a_n_i}),
    .sync_o(sense_n_s)
  );

  assign scan_go = scan_tick_i;
  assign any_volt = ~&sense_n_s;
  assign all_volt = ~|sense_n_s;

  dio_fail_cnt #(
    .FAIL_LIMIT(FAIL_LIMIT)
  ) u_fail_cnt (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .scan_i(scan_go),
    .any_volt_i(any_volt),
    .override_o(override),
    .count_o(volt_fail_count_o)
  );

  // Image qualification
  assign take_img = scan_go && (any_volt || override);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      work_ff <= '1;
    end else if (ce_i && take_img) begin
      work_ff <= img_s;
    end
  end

  // Diagnostic byte refreshed each scan
  assign nxt_diag = all_volt ? BYTE_ZERO : (BYTE_ZERO | (8'h01 << DIAG_VOLT_OFF_BIT));

  // Output latch control
  assign hold_on = ~work_ff.hold_status_n;
  assign out_on = ~out_n_ff;

  always_comb begin
    nxt_out_n = out_n_ff;
    if (interlink_timeout_i) begin
      nxt_out_n = out_n_ff | ~hold_on;
    end else if (point_message_valid_i) begin
      nxt_out_n = {point_message_data_i[POLL_OUT1_BIT],
                   point_message_data_i[POLL_OUT0_BIT]};
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_n_ff <= OUT_RESET;
    end else if (ce_i) begin
      out_n_ff <= nxt_out_n;
    end
  end

  assign out0_drive_n_o = out_n_ff[0];
  assign out1_drive_n_o = out_n_ff[1];
  assign coil_mon_en_o = ~out_on & ~(~nxt_out_n);

  // Response build, active-high sense
  assign coil_rep = out_on | ~work_ff.coil_ok_n;
  assign nxt_resp1 = ~work_ff.din_n[7:0];
  assign nxt_resp2 = {~work_ff.supply_present_n[1], ~work_ff.supply_present_n[0],
                      coil_rep[1], coil_rep[0], ~work_ff.hold_status_n[0],
                      ~work_ff.din_n[10:8]};

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      resp1_ff <= BYTE_ZERO;
      resp2_ff <= BYTE_ZERO;
      diag_ff <= BYTE_ZERO;
    end else if (ce_i) begin
      resp1_ff <= nxt_resp1;
      resp2_ff <= nxt_resp2;
      if (scan_go) begin
        diag_ff <= nxt_diag;
      end
    end
  end

  assign resp_o.byte1 = resp1_ff;
  assign resp_o.byte2 = resp2_ff;
  assign diag_o = diag_ff;
  assign volt_fail_override_o = override;
endmodule : dio_scan

// file: dv/dio_scan_chk.sv
module dio_scan_chk
  import dio_pkg::*;
#(
  parameter int FAIL_LIMIT = FAIL_LIMIT_DEF
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic scan_tick_i,
  input wire logic sense_volt_a_n_i,
  input wire logic sense_volt_b_n_i,
  input wire logic sense_volt_c_n_i,
  input wire logic point_message_valid_i,
  input wire logic [7:0] point_message_data_i,
  input wire logic interlink_timeout_i,
  input wire logic out0_drive_n_o,
  input wire logic out1_drive_n_o,
  input wire logic [1:0] coil_mon_en_o,
  input wire dio_pkg::dio_resp_t resp_o,
  input wire logic [7:0] diag_o,
  input wire logic volt_fail_override_o,
  input wire logic [FAIL_CNT_W-1:0] volt_fail_count_o
);
  wire scan = ce_i & scan_tick_i;
  wire none_v = sense_volt_a_n_i & sense_volt_b_n_i & sense_volt_c_n_i;
  wire some_off = sense_volt_a_n_i | sense_volt_b_n_i | sense_volt_c_n_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_poll;
    ce_i && point_message_valid_i && !interlink_timeout_i;
  endsequence
  sequence s_on0;
    !out0_drive_n_o ##1 !out0_drive_n_o;
  endsequence
  AST_POLL: assert property (s_poll |=>
    {out1_drive_n_o, out0_drive_n_o} == $past(point_message_data_i[1:0])) else $error("poll");
  AST_MON: assert property ((coil_mon_en_o & ~{out1_drive_n_o, out0_drive_n_o}) == 2'h0)
    else $error("monitor with drive");
  AST_CNT0: assert property (!none_v [*4] ##0 scan |=> volt_fail_count_o == 8'h00)
    else $error("count not zero");
  AST_INC: assert property (none_v [*4] ##0 scan && volt_fail_count_o < 8'hFF |=>
    volt_fail_count_o == $past(volt_fail_count_o) + 8'h01) else $error("count step");
  AST_DIAG: assert property (some_off [*4] ##0 scan |=> diag_o[DIAG_VOLT_OFF_BIT])
    else $error("diag bit");
  AST_OVR: assert property (volt_fail_override_o == (volt_fail_count_o > FAIL_LIMIT))
    else $error("override");
  AST_COIL: assert property (s_on0 |-> resp_o.byte2[RSP2_COIL0_BIT])
    else $error("coil mask");
  AST_TMO: assert property (ce_i && interlink_timeout_i && out0_drive_n_o |=> out0_drive_n_o)
    else $error("timeout drive");
  AST_HOLD0: assert property (ce_i && interlink_timeout_i && resp_o.byte2[RSP2_HOLD0_BIT] &&
    $past(ce_i) && !$past(scan_tick_i) && !out0_drive_n_o |=> !out0_drive_n_o)
    else $error("held channel dropped");
  AST_FAIL0: assert property (ce_i && interlink_timeout_i && !resp_o.byte2[RSP2_HOLD0_BIT] &&
    $past(ce_i) && !$past(scan_tick_i) |=> out0_drive_n_o)
    else $error("failsafe not reached");
endmodule : dio_scan_chk
bind dio_scan dio_scan_chk #(.FAIL_LIMIT(FAIL_LIMIT)) i_chk (.*);

// file: dv/dio_ctl_model.sv
module dio_ctl_model (
  input wire logic core_clk_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic timeout_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_o = 1'b0;
    data_o = 8'hA5;
    timeout_o = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    @(posedge core_clk_i);
    #1 valid_o = 1'b1;
    data_o = b;
    @(posedge core_clk_i);
    #1 valid_o = 1'b0;
    data_o = ~b;
  endtask : send
  task automatic drop_link();
    @(posedge core_clk_i);
    #1 timeout_o = 1'b1;
    @(posedge core_clk_i);
    #1 timeout_o = 1'b0;
  endtask : drop_link
endmodule : dio_ctl_model

// file: dv/tb_dio_scan.sv
module tb_dio_scan;
  timeunit 1ns;
  timeprecision 1ns;
  import dio_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic tick = 1'b0;
  logic [2:0] sv_n = 3'h6;
  dio_image_t img = 17'h0A5A6;
  logic valid, tmo, o0, o1, ovr;
  logic [1:0] cmon;
  logic [7:0] data, diag, cnt;
  dio_resp_t rsp;
  int err_total = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  dio_scan #(.FAIL_LIMIT(2)) i_dut (.core_clk_i(clk), .rstn_i(rstn), .ce_i(1'b1),
    .scan_tick_i(tick), .image_n_i(img), .sense_volt_a_n_i(sv_n[0]),
    .sense_volt_b_n_i(sv_n[1]), .sense_volt_c_n_i(sv_n[2]), .point_message_valid_i(valid),
    .point_message_data_i(data), .interlink_timeout_i(tmo), .out0_drive_n_o(o0),
    .out1_drive_n_o(o1), .coil_mon_en_o(cmon), .resp_o(rsp), .diag_o(diag),
    .volt_fail_override_o(ovr), .volt_fail_count_o(cnt));
  dio_ctl_model i_ctl (.core_clk_i(clk), .valid_o(valid), .data_o(data), .timeout_o(tmo));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic scan();
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(2);
  endtask : scan
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] rsp_of(input dio_image_t m, input logic [1:0] on);
    return ~{m.supply_present_n, m.coil_ok_n & ~on, m.hold_status_n[0], m.din_n};
  endfunction : rsp_of
  task automatic finish_test();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    #100us;
    err_total++;
    finish_test();
  end
  initial begin
    logic [15:0] e;
    cyc(8);
    chk({o1, o0, rsp}, {2'h3, 16'h0000});
    rstn = 1'b1;
    cyc(3);
    scan();
    chk(rsp, rsp_of(img, 2'h0));
    i_ctl.send(8'hFC);
    chk({cmon, o1, o0}, {2'h0, 2'h0});
    scan();
    chk(rsp, rsp_of(img, 2'h3));
    i_ctl.drop_link();
    chk({cmon, o1, o0}, {2'h2, 2'h2});
    i_ctl.send(8'h03);
    e = rsp_of(img, 2'h0);
    sv_n = 3'h7;
    img = ~img;
    cyc(3);
    scan();
    chk({diag[0], cnt, rsp}, {1'b1, 8'h01, e});
    repeat (3) scan();
    chk({ovr, rsp}, {1'b1, rsp_of(img, 2'h0)});
    sv_n = 3'h5;
    cyc(3);
    scan();
    chk({diag[0], ovr, cnt}, {1'b1, 9'h000});
    i_ctl.send(8'hFC);
    i_ctl.drop_link();
    chk({cmon, o1, o0}, {2'h1, 2'h1});
    finish_test();
  end
endmodule : tb_dio_scan
